/* File: hw/fbp_flash_guard.sv */
// Flash protection and operation timing unit with its APB register file.
// Assumes APB master on clock_i; read port driven by logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_guard
   import fbp_pkg::*;
#(
   parameter int NWORDS = FBP_BLOCK_BYTES / 4 * 2
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire fbp_rd_req_t rd_req_i,
   output fbp_rd_rsp_t rd_rsp_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   localparam int IDX_W = $clog2(NWORDS);
   logic [31:0] mem_q [NWORDS];
   logic [31:0] rd_perm_q [FBP_PERM_REGS];
   logic [31:0] pg_perm_q [FBP_PERM_REGS];
   logic [31:0] rd_nv_q [FBP_PERM_REGS] = '{default: FBP_PERM_RESET};
   logic [31:0] pg_nv_q [FBP_PERM_REGS] = '{default: FBP_PERM_RESET};
   logic reload_q;
   logic [FBP_US_W-1:0] cycles_per_us_reload_q;
   logic [31:0] addr_q;
   logic [31:0] data_q;
   logic [3:0] ctrl_q;
   logic [1:0] raw_q;
   logic [1:0] flash_irq_mask_reg_q;
   fbp_state_t state_q;
   logic [FBP_CYC_W-1:0] cyc_q;
   logic [FBP_US_W-1:0] us_q;
   logic [IDX_W-1:0] wipe_q;
   fbp_rd_rsp_t rsp_q;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire wr_en = psel_i & penable_i & pwrite_i;
   wire sel_addr = paddr_i == FBP_OFS_ADDR;
   wire sel_data = paddr_i == FBP_OFS_DATA;
   wire sel_ctrl = paddr_i == FBP_OFS_CTRL;
   wire sel_raw = paddr_i == FBP_OFS_RAW;
   wire sel_mask = paddr_i == FBP_OFS_MASK;
   wire sel_misc = paddr_i == FBP_OFS_MISC;
   wire sel_usr = paddr_i == FBP_OFS_US_RELOAD;
   wire sel_rp0 = (paddr_i == FBP_OFS_READ_PERMIT0) | (paddr_i == FBP_OFS_READ_PERMIT0B);
   wire sel_rp1 = paddr_i == FBP_OFS_READ_PERMIT1;
   wire sel_pp0 = (paddr_i == FBP_OFS_PROG_PERMIT0) | (paddr_i == FBP_OFS_PROG_PERMIT0B);
   wire sel_pp1 = paddr_i == FBP_OFS_PROG_PERMIT1;
   wire hit = sel_addr | sel_data | sel_ctrl | sel_raw | sel_mask | sel_misc | sel_usr
      | sel_rp0 | sel_rp1 | sel_pp0 | sel_pp1;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;

   // ----------------------------------------------------------------
   // Permission lookup
   // ----------------------------------------------------------------
   wire [FBP_BLK_W-1:0] op_blk = addr_q[FBP_BLOCK_LSB +: FBP_BLK_W];
   wire [FBP_BLK_W-1:0] rd_blk = rd_req_i.addr[FBP_BLOCK_LSB +: FBP_BLK_W];
   wire op_permit = pg_perm_q[op_blk[5]][op_blk[4:0]];
   wire rd_permit = rd_perm_q[rd_blk[5]][rd_blk[4:0]];
   wire rd_ok = rd_permit | rd_req_i.fetch;
   wire [IDX_W-1:0] rd_idx = rd_req_i.addr[FBP_WORD_LSB +: IDX_W];
   wire [IDX_W-1:0] op_idx = addr_q[FBP_WORD_LSB +: IDX_W];
   wire [IDX_W-1:0] unit_base = {op_idx[IDX_W-1:FBP_UNIT_LSB-FBP_WORD_LSB],
      {(FBP_UNIT_LSB - FBP_WORD_LSB){1'b0}}};

   wire ctrl_wr = wr_en & sel_ctrl & (state_q == FBP_IDLE);
   wire start_prog = ctrl_wr & pwdata_i[FBP_CTRL_PROG];
   wire start_erase = ctrl_wr & pwdata_i[FBP_CTRL_ERASE] & ~pwdata_i[FBP_CTRL_PROG];
   wire start_commit = ctrl_wr & pwdata_i[FBP_CTRL_COMMIT]
      & ~pwdata_i[FBP_CTRL_PROG] & ~pwdata_i[FBP_CTRL_ERASE];
   wire deny_op = (start_prog | start_erase) & ~op_permit;
   wire deny_rd = rd_req_i.req & ~rd_ok;

   // ----------------------------------------------------------------
   // Microsecond timebase
   // ----------------------------------------------------------------
   wire us_tick = (state_q != FBP_IDLE) & (cyc_q == '0);
   wire [FBP_US_W-1:0] op_len = (state_q == FBP_PROG) ? FBP_US_W'(FBP_T_PROG_US)
      : FBP_US_W'(FBP_T_ERASE_US);
   wire op_done = us_tick & (us_q == op_len - FBP_US_W'(1));
   wire wipe_last = &wipe_q[FBP_UNIT_LSB-FBP_WORD_LSB-1:0];

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cyc_q <= '0;
         us_q <= '0;
      end else if (state_q == FBP_IDLE || state_q == FBP_WIPE) begin
         cyc_q <= cycles_per_us_reload_q;
         us_q <= '0;
      end else begin
         cyc_q <= us_tick ? cycles_per_us_reload_q : cyc_q - FBP_CYC_W'(1);
         us_q <= us_tick ? us_q + FBP_US_W'(1) : us_q;
      end
   end

   // ----------------------------------------------------------------
   // Operation sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= FBP_IDLE;
         wipe_q <= '0;
      end else begin
         unique case (state_q)
            FBP_IDLE: begin
               if (start_prog && op_permit) begin
                  state_q <= FBP_PROG;
               end else if (start_erase && op_permit) begin
                  state_q <= FBP_ERASE;
               end else if (start_commit) begin
                  state_q <= FBP_COMMIT;
               end
               wipe_q <= unit_base;
            end
            FBP_PROG, FBP_COMMIT: begin
               if (op_done) begin
                  state_q <= FBP_IDLE;
               end
            end
            FBP_ERASE: begin
               if (op_done) begin
                  state_q <= FBP_WIPE;
               end
            end
            FBP_WIPE: begin
               wipe_q <= wipe_q + IDX_W'(1);
               if (wipe_last) begin
                  state_q <= FBP_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Flash array
   // ----------------------------------------------------------------
   generate
      for (genvar w = 0; w < NWORDS; w++) begin : g_word
         always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
               mem_q[w] <= FBP_ERASED_WORD;
            end else if (state_q == FBP_WIPE && wipe_q == IDX_W'(w)) begin
               mem_q[w] <= FBP_ERASED_WORD;
            end else if (state_q == FBP_PROG && op_done && op_idx == IDX_W'(w)) begin
               mem_q[w] <= mem_q[w] & data_q;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Protection registers
   // ----------------------------------------------------------------
   generate
      for (genvar r = 0; r < FBP_PERM_REGS; r++) begin : g_perm
         wire rsel = (r == 0) ? sel_rp0 : sel_rp1;
         wire psel = (r == 0) ? sel_pp0 : sel_pp1;
         wire do_commit = (state_q == FBP_COMMIT) & op_done & (addr_q[1] == 1'(r));
         // Committed copies stand for the nonvolatile store and survive reset
         always_ff @(posedge clock_i) begin
            if (do_commit && !addr_q[0]) begin
               rd_nv_q[r] <= rd_nv_q[r] & rd_perm_q[r];
            end
            if (do_commit && addr_q[0]) begin
               pg_nv_q[r] <= pg_nv_q[r] & pg_perm_q[r];
            end
         end
         always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
               rd_perm_q[r] <= FBP_PERM_RESET;
               pg_perm_q[r] <= FBP_PERM_RESET;
            end else if (reload_q) begin
               rd_perm_q[r] <= rd_nv_q[r];
               pg_perm_q[r] <= pg_nv_q[r];
            end else begin
               if (wr_en && rsel) begin
                  rd_perm_q[r] <= rd_perm_q[r] & pwdata_i;
               end
               if (wr_en && psel) begin
                  pg_perm_q[r] <= pg_perm_q[r] & pwdata_i;
               end
            end
         end
      end
   endgenerate

   // Active policy reloads from the committed copies after reset
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reload_q <= 1'b1;
      end else begin
         reload_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Control, mask and status registers
   // ----------------------------------------------------------------
   wire op_finish = ((state_q == FBP_PROG) | (state_q == FBP_COMMIT)) & op_done;
   wire wipe_finish = (state_q == FBP_WIPE) & wipe_last;
   wire [1:0] raw_set = {op_finish | wipe_finish, deny_op | deny_rd};
   wire [1:0] raw_clr = (wr_en & sel_misc) ? pwdata_i[1:0] : 2'b00;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         addr_q <= '0;
         data_q <= '0;
      end else if (state_q == FBP_IDLE) begin
         if (wr_en && sel_addr) begin
            addr_q <= pwdata_i;
         end
         if (wr_en && sel_data) begin
            data_q <= pwdata_i;
         end
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q <= '0;
      end else if (start_prog || start_erase || start_commit) begin
         ctrl_q <= deny_op ? 4'h0 : pwdata_i[3:0];
      end else if (raw_set[FBP_IRQ_DONE]) begin
         ctrl_q <= '0;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flash_irq_mask_reg_q <= '0;
      end else if (wr_en && sel_mask) begin
         flash_irq_mask_reg_q <= pwdata_i[1:0];
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cycles_per_us_reload_q <= FBP_US_RELOAD_RESET;
      end else if (wr_en && sel_usr) begin
         cycles_per_us_reload_q <= pwdata_i[FBP_US_W-1:0];
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         raw_q <= '0;
      end else begin
         raw_q <= (raw_q & ~raw_clr) | raw_set;
      end
   end

   assign irq_o = |(raw_q & flash_irq_mask_reg_q);

   // ----------------------------------------------------------------
   // Array read port
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= rd_req_i.req;
         rsp_q.refused <= deny_rd;
         rsp_q.data <= rd_ok ? mem_q[rd_idx] : FBP_ZERO_WORD;
      end
   end
   assign rd_rsp_o = rsp_q;

   // ----------------------------------------------------------------
   // APB read data
   // ----------------------------------------------------------------
   wire [31:0] rd_word = sel_addr ? addr_q
      : sel_data ? data_q
      : sel_ctrl ? {28'h000_0000, ctrl_q}
      : sel_raw ? {30'h000_0000, raw_q}
      : sel_mask ? {30'h000_0000, flash_irq_mask_reg_q}
      : sel_misc ? {30'h000_0000, raw_q & flash_irq_mask_reg_q}
      : sel_usr ? {24'h00_0000, cycles_per_us_reload_q}
      : sel_rp0 ? rd_perm_q[0]
      : sel_rp1 ? rd_perm_q[1]
      : sel_pp0 ? pg_perm_q[0]
      : sel_pp1 ? pg_perm_q[1]
      : FBP_ZERO_WORD;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prdata_o <= '0;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= rd_word;
      end
   end

endmodule : fbp_flash_guard
`default_nettype wire

/* File: hw/fbp_pkg.sv */
// Constants and carrier types for the flash block protection and timing unit.
// Assumes an APB slave with 32-bit data and a single 50 MHz system clock.
//
// Contract
// - Flash divided into independently erasable 1 KB units
// - Erase sets every bit of unit to one
// - Word program only clears bits, never sets
// - Protection granted per pair of units, 2 KB
// - One program and one read bit per block
// - Program bit zero refuses program and erase
// - Read bit zero allows only instruction fetch
// - Read-only block readable, never changed
// - Execute-only block allows fetch only, no changes
// - Refused change suppressed, optional masked interrupt
// - Refused data read returns all zeros
// - Refused read may raise masked interrupt
// - Controller times operations from cycles-per-microsecond count
// - Protection bits leave factory all ones
// - Written bits act at once, permanent after commit
// - Uncommitted cleared bits restored by power-on reset
// - Protection writes only clear bits, never set
package fbp_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int FBP_WORD_W = 32;
   localparam int FBP_UNIT_BYTES = 1024;
   localparam int FBP_BLOCK_BYTES = 2048;
   localparam int FBP_NBLOCKS = 64;
   localparam int FBP_PERM_REGS = 2;
   localparam int FBP_ADDR_W = 17;
   localparam int FBP_WORD_LSB = 2;
   localparam int FBP_UNIT_LSB = 10;
   localparam int FBP_BLOCK_LSB = 11;
   localparam int FBP_BLK_W = 6;
   localparam int FBP_UNIT_WORDS = FBP_UNIT_BYTES / 4;

   // ----------------------------------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------------------------------
   localparam logic [11:0] FBP_OFS_READ_PERMIT0 = 12'h0130;
   localparam logic [11:0] FBP_OFS_PROG_PERMIT0 = 12'h0134;
   localparam logic [11:0] FBP_OFS_US_RELOAD = 12'h0140;
   localparam logic [11:0] FBP_OFS_READ_PERMIT0B = 12'h0200;
   localparam logic [11:0] FBP_OFS_READ_PERMIT1 = 12'h0204;
   localparam logic [11:0] FBP_OFS_PROG_PERMIT0B = 12'h0400;
   localparam logic [11:0] FBP_OFS_PROG_PERMIT1 = 12'h0404;
   localparam logic [11:0] FBP_OFS_CTRL = 12'h0008;
   localparam logic [11:0] FBP_OFS_ADDR = 12'h0000;
   localparam logic [11:0] FBP_OFS_DATA = 12'h0004;
   localparam logic [11:0] FBP_OFS_RAW = 12'h000c;
   localparam logic [11:0] FBP_OFS_MASK = 12'h0010;
   localparam logic [11:0] FBP_OFS_MISC = 12'h0014;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int FBP_CTRL_PROG = 0;
   localparam int FBP_CTRL_ERASE = 1;
   localparam int FBP_CTRL_COMMIT = 3;
   localparam int FBP_IRQ_ACCESS = 0;
   localparam int FBP_IRQ_DONE = 1;
   localparam logic [31:0] FBP_PERM_RESET = 32'hffff_ffff;
   localparam logic [7:0] FBP_US_RELOAD_RESET = 8'h31;
   localparam logic [31:0] FBP_ERASED_WORD = 32'hffff_ffff;
   localparam logic [31:0] FBP_ZERO_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Timing: program 20 us, erase and commit 24 us per step
   // ----------------------------------------------------------------
   localparam int FBP_T_PROG_US = 20;
   localparam int FBP_T_ERASE_US = 24;
   localparam int FBP_CYC_W = 8;
   localparam int FBP_US_W = 8;

   typedef enum logic [4:0] {
      FBP_IDLE = 5'b00001,
      FBP_PROG = 5'b00010,
      FBP_ERASE = 5'b00100,
      FBP_WIPE = 5'b01000,
      FBP_COMMIT = 5'b10000
   } fbp_state_t;

   typedef struct packed {
      logic req;
      logic fetch;
      logic [FBP_ADDR_W-1:0] addr;
   } fbp_rd_req_t;

   typedef struct packed {
      logic valid;
      logic refused;
      logic [FBP_WORD_W-1:0] data;
   } fbp_rd_rsp_t;

endpackage : fbp_pkg

/* File: tb/fbp_guard_monitor.sv */
// Concurrent checks on the ports of the flash guard.
// Assumes it is bound into fbp_flash_guard; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module fbp_guard_monitor
   import fbp_pkg::*;
#(
   parameter int NWORDS = 1024
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire fbp_rd_req_t rd_req_i,
   input wire fbp_rd_rsp_t rd_rsp_o,
   input wire logic irq_o
);
   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire logic mapped;
   assign mapped = paddr_i inside {FBP_OFS_READ_PERMIT0, FBP_OFS_PROG_PERMIT0,
      FBP_OFS_US_RELOAD, FBP_OFS_READ_PERMIT0B, FBP_OFS_READ_PERMIT1, FBP_OFS_PROG_PERMIT0B,
      FBP_OFS_PROG_PERMIT1, FBP_OFS_CTRL, FBP_OFS_ADDR, FBP_OFS_DATA, FBP_OFS_RAW,
      FBP_OFS_MASK, FBP_OFS_MISC};

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);

   refused_zero_a: assert property (rd_rsp_o.valid && rd_rsp_o.refused |->
      rd_rsp_o.data == FBP_ZERO_WORD) else $error("refused read carries data");
   rsp_follows_a: assert property (rd_req_i.req |=> rd_rsp_o.valid)
      else $error("read response missing");
   rsp_cause_a: assert property (rd_rsp_o.valid |-> $past(rd_req_i.req))
      else $error("read response without request");
   fetch_allowed_a: assert property (rd_req_i.req && rd_req_i.fetch |=> !rd_rsp_o.refused)
      else $error("instruction fetch refused");
   refused_data_a: assert property (rd_rsp_o.refused |-> !$past(rd_req_i.fetch))
      else $error("refusal on a fetch");
   irq_clear_a: assert property ($fell(irq_o) |-> $past(psel_i && penable_i && pwrite_i))
      else $error("interrupt dropped without a write");
   slverr_map_a: assert property (pslverr_o == (psel_i && penable_i && !mapped))
      else $error("error response does not match address map");
   ready_now_a: assert property (psel_i && !penable_i ##1 psel_i && penable_i |-> pready_o)
      else $error("access phase not answered");
endmodule : fbp_guard_monitor

bind fbp_flash_guard fbp_guard_monitor #(.NWORDS(NWORDS)) u_mon (
   .clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .rd_req_i(rd_req_i), .rd_rsp_o(rd_rsp_o),
   .irq_o(irq_o)
);
`default_nettype wire

/* File: tb/fbp_core_port.sv */
// Model of the core and debugger read requester in front of the array port.
// Assumes the bench pulses go_i for one cycle per read.
`timescale 1ns/1ps
`default_nettype none
module fbp_core_port
   import fbp_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic go_i,
   input wire logic fetch_i,
   input wire logic [FBP_ADDR_W-1:0] addr_i,
   output fbp_rd_req_t rd_req_o
);
   // Idle cycles invert the qualifiers each cycle, so stale values return on every second idle cycle
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_req_o <= '0;
      end else if (go_i) begin
         rd_req_o.req <= 1'b1;
         rd_req_o.fetch <= fetch_i;
         rd_req_o.addr <= addr_i;
      end else begin
         rd_req_o.req <= 1'b0;
         rd_req_o.fetch <= ~rd_req_o.fetch;
         rd_req_o.addr <= ~rd_req_o.addr;
      end
   end
endmodule : fbp_core_port
`default_nettype wire

/* File: tb/fbp_flash_guard_test.sv */
// Self-checking bench: APB master, read-port partner and queue scoreboard.
// Assumes fbp_core_port and fbp_guard_monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_guard_test
   import fbp_pkg::*;
();
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, irq;
   logic go = 1'b0;
   logic fetch = 1'b0;
   logic [FBP_ADDR_W-1:0] addr = '0;
   fbp_rd_req_t rd_req;
   fbp_rd_rsp_t rd_rsp;
   logic [32:0] exp_q[$];
   logic [31:0] seed = 32'h0000_58f4;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc_cnt = 0;

   always #20 clock_i = ~clock_i;
   always @(posedge clock_i) cyc_cnt <= cyc_cnt + 1;

   fbp_flash_guard #(.NWORDS(1024)) dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rd_req_i(rd_req),
      .rd_rsp_o(rd_rsp), .irq_o(irq));
   fbp_core_port u_core (.clock_i(clock_i), .nrst_i(nrst_i), .go_i(go), .fetch_i(fetch),
      .addr_i(addr), .rd_req_o(rd_req));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, want, seen);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do begin
         @(posedge clock_i);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check("apb_read", {e, r}, {1'b0, want});
   endtask : rd_chk

   task automatic op(input logic [31:0] c, input int lo, input int hi);
      logic [31:0] r;
      logic e;
      int t0;
      int n;
      t0 = cyc_cnt;
      n = 0;
      wr(12'h008, c);
      do begin
         apb(1'b0, 12'h008, 32'h0, r, e);
         n++;
      end while (r !== 32'h0 && n < 3000);
      check("op_time", 33'(cyc_cnt - t0 >= lo && cyc_cnt - t0 <= hi), 33'h1);
   endtask : op

   task automatic prog(input logic [31:0] a, input logic [31:0] d);
      wr(12'h000, a);
      wr(12'h004, d);
      op(32'h0000_0001, 100, 115);
   endtask : prog

   task automatic port(input logic f, input logic [16:0] a, input logic rf,
                       input logic [31:0] d);
      exp_q.push_back({rf, d});
      @(posedge clock_i);
      go <= 1'b1;
      fetch <= f;
      addr <= a;
      @(posedge clock_i);
      go <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask : port

   // ------------------------------------------------------------
   // Scoreboard and watchdog
   // ------------------------------------------------------------
   always @(posedge clock_i) begin
      if (rd_rsp.valid === 1'b1) begin
         if (exp_q.size() == 0) check("rsp_extra", 33'h0, 33'h1);
         else check("rd_rsp", {rd_rsp.refused, rd_rsp.data}, exp_q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      n_mismatch++;
      summarize();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] d0, d1, d2, d3, r;
      logic e;
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      rd_chk(12'h130, FBP_PERM_RESET);
      rd_chk(12'h404, FBP_PERM_RESET);
      rd_chk(12'h140, 32'h0000_0031);
      apb(1'b0, 12'h0fc, 32'h0, r, e);
      check("unmapped_err", {32'h0, e}, 33'h1);
      wr(12'h140, 32'h0000_0004);
      d0 = xs();
      d1 = xs();
      d2 = xs();
      d3 = xs();
      prog(32'h0000_0000, d0);
      port(1'b0, 17'h0000, 1'b0, d0);
      prog(32'h0000_0000, d1);
      port(1'b0, 17'h0000, 1'b0, d0 & d1);
      prog(32'h0000_0400, d2);
      prog(32'h0000_0800, d3);
      wr(12'h000, 32'h0000_0000);
      op(32'h0000_0002, 376, 395);
      port(1'b0, 17'h0000, 1'b0, FBP_ERASED_WORD);
      port(1'b0, 17'h0400, 1'b0, d2);
      wr(12'h134, 32'hffff_fffe);
      wr(12'h134, 32'hffff_ffff);
      rd_chk(12'h134, 32'hffff_fffe);
      wr(12'h014, 32'h0000_0003);
      wr(12'h010, 32'h0000_0001);
      wr(12'h000, 32'h0000_0400);
      wr(12'h004, 32'h0000_0000);
      wr(12'h008, 32'h0000_0001);
      rd_chk(12'h008, 32'h0000_0000);
      wr(12'h008, 32'h0000_0002);
      rd_chk(12'h008, 32'h0000_0000);
      rd_chk(12'h00c, 32'h0000_0001);
      @(negedge clock_i);
      check("irq", {32'h0, irq}, 33'h1);
      port(1'b0, 17'h0400, 1'b0, d2);
      wr(12'h014, 32'h0000_0001);
      @(negedge clock_i);
      check("irq", {32'h0, irq}, 33'h0);
      wr(12'h200, 32'hffff_fffe);
      rd_chk(12'h130, 32'hffff_fffe);
      port(1'b0, 17'h0400, 1'b1, FBP_ZERO_WORD);
      port(1'b1, 17'h0400, 1'b0, d2);
      port(1'b0, 17'h0800, 1'b0, d3);
      rd_chk(12'h00c, 32'h0000_0001);
      wr(12'h000, 32'h0000_0001);
      op(32'h0000_0008, 120, 135);
      rd_chk(12'h00c, 32'h0000_0003);
      rd_chk(12'h134, 32'hffff_fffe);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      rd_chk(12'h130, FBP_PERM_RESET);
      rd_chk(12'h134, 32'hffff_fffe);
      check("rsp_left", 33'(exp_q.size()), 33'h0);
      summarize();
   end
endmodule : fbp_flash_guard_test
`default_nettype wire
